/* File: fpc_regs.svh */
// Constants for the flash protection command host: command codes, addresses,
// controller register offsets and bus timing counts.
// Assumes an x8 flash bus with unlock addresses AAA/555 and a 125 MHz clock.
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

`define FPC_ADDR_UNLOCK1 24'h000aaa
`define FPC_ADDR_UNLOCK2 24'h000555
`define FPC_DATA_UNLOCK1 8'haa
`define FPC_DATA_UNLOCK2 8'h55
`define FPC_CMD_RESET 8'hf0
`define FPC_CMD_AUTOSEL 8'h90
`define FPC_CMD_QUERY 8'h98
`define FPC_ADDR_QUERY 24'h0000aa
`define FPC_CMD_PROGRAM 8'ha0
`define FPC_CMD_BUF_LOAD 8'h25
`define FPC_CMD_BUF_CONFIRM 8'h29
`define FPC_CMD_BYPASS 8'h20
`define FPC_CMD_ERASE 8'h80
`define FPC_CMD_SECTOR_ERASE 8'h30
`define FPC_CMD_CHIP_ERASE 8'h10
`define FPC_CMD_SUSPEND 8'hb0
`define FPC_CMD_RESUME 8'h30
`define FPC_CMD_EXIT1 8'h90
`define FPC_CMD_EXIT2 8'h00
`define FPC_CMD_LOCKREG 8'h40
`define FPC_CMD_PASSWORD 8'h60
`define FPC_CMD_PERSIST 8'hc0
`define FPC_CMD_FREEZE 8'h50
`define FPC_CMD_VOLATILE 8'he0
`define FPC_CMD_PW_UNLOCK2 8'h03
`define FPC_ADDR_VERIFY 24'h000004
`define FPC_ADDR_SECURE 24'h000006
`define FPC_PW_WORDS 8
`define FPC_LOCK_SECURE 0
`define FPC_LOCK_PERSIST 1
`define FPC_LOCK_PASSWORD 2

// Controller registers, word offsets
`define FPC_REG_CMD 4'h0
`define FPC_REG_ADDR 4'h1
`define FPC_REG_DATA 4'h2
`define FPC_REG_STATUS 4'h3
`define FPC_REG_RDATA 4'h4
`define FPC_REG_PW_LO 4'h5
`define FPC_REG_PW_HI 4'h6

// Bus cycle timing
`define FPC_T_WE_NS 40
`define FPC_T_WE_CYC ((`FPC_T_WE_NS + 7) / 8)
`define FPC_T_RD_NS 120
`define FPC_T_RD_CYC ((`FPC_T_RD_NS + 7) / 8)

`endif

/* File: fpc_pkg.sv */
// Types for the flash protection command host.
// Constants live in fpc_regs.svh.
`default_nettype none
package fpc_pkg;
	typedef enum logic [4:0] {
		FPC_OP_READ,
		FPC_OP_RESET,
		FPC_OP_AUTOSEL_READ,
		FPC_OP_QUERY,
		FPC_OP_PROGRAM,
		FPC_OP_BUF_PROGRAM,
		FPC_OP_BUF_ABORT_RESET,
		FPC_OP_BYPASS_ENTER,
		FPC_OP_BYPASS_PROGRAM,
		FPC_OP_BYPASS_RESET,
		FPC_OP_SECTOR_ERASE,
		FPC_OP_CHIP_ERASE,
		FPC_OP_SUSPEND,
		FPC_OP_RESUME,
		FPC_OP_SET_ENTER,
		FPC_OP_SET_PROGRAM,
		FPC_OP_SET_ERASE_ALL,
		FPC_OP_SET_READ,
		FPC_OP_SET_EXIT,
		FPC_OP_PW_UNLOCK
	} fpc_op_e;

	typedef enum {
		FPC_IDLE,
		FPC_SETUP,
		FPC_STROBE,
		FPC_HOLD,
		FPC_RDWAIT,
		FPC_DONE
	} fpc_state_e;
endpackage : fpc_pkg
`default_nettype wire

/* File: fpc_host.sv */
// Host controller that issues flash command sequences over the flash bus.
// Software writes address, data and an op code, then reads status and data.
// Behaviour
// - Array read is one plain read cycle
// - Reset command returns from autoselect or error
// - Buffer locations stay in start page
// - Abort reset always full three cycles
// - Bypass enter before bypass program; reset leaves
// - Protection set left by 90 then 00
// - One A0 program per password portion
// - Unlock: 25, 03, eight words, 29
// - Persistent set entry C0, program 00
// - Freeze set entry 50, set 00
// - Volatile entry E0, set 00, clear 01
`timescale 1ns/1ps
`default_nettype none
`include "fpc_regs.svh"

module fpc_host #(
	parameter int ADDR_W = 24,
	parameter int BUF_PAGE_W = 5
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	output logic [ADDR_W-1:0] o_flash_addr,
	output logic [7:0] o_flash_dq_out,
	output logic o_flash_dq_oe,
	input wire logic [7:0] i_flash_dq_in,
	output logic o_flash_ce_n,
	output logic o_flash_we_n,
	output logic o_flash_oe_n
);
	// Address and page fields are sized for at most 24 and 8 bits
	if (ADDR_W < 16 || ADDR_W > 24 || BUF_PAGE_W < 1 || BUF_PAGE_W > 8)
		$error("fpc_host: unsupported parameters");

	localparam int SEQ_MAX = 12;
	localparam int TW = `FPC_T_WE_CYC;
	localparam int TR = `FPC_T_RD_CYC;

	typedef struct packed {
		fpc_pkg::fpc_state_e st;
		logic [4:0] op;
		logic [23:0] addr;
		logic [7:0] data;
		logic [7:0] rdata;
		logic [63:0] pw;
		logic [3:0] step;
		logic [3:0] nsteps;
		logic [4:0] tmr;
		logic busy;
		logic refused;
		logic bypass;
		logic suspended;
		logic erasing;
		logic in_set;
		logic autosel;
		logic [7:0] set_kind;
		logic [7:0] dq_s1, dq_s2, dq_s3, dq_ok;
		logic [31:0] rd_q;
		logic [23:0] fa;
		logic [7:0] fd;
		logic oe_dq;
		logic ce_n;
		logic we_n;
		logic oe_n;
	} fpc_host_s;

	fpc_host_s cur;
	fpc_host_s nxt;

	// One bus cycle of a sequence: address, data, and whether it is a read
	function automatic logic [32:0] seq_cycle(input logic [4:0] op, input logic [3:0] i,
		input logic [23:0] a, input logic [7:0] d, input logic [63:0] pw);
		logic [32:0] c;
		c = {1'b0, `FPC_ADDR_UNLOCK1, `FPC_DATA_UNLOCK1};
		if (i == 4'h1)
			c = {1'b0, `FPC_ADDR_UNLOCK2, `FPC_DATA_UNLOCK2};
		unique case (fpc_pkg::fpc_op_e'(op))
			fpc_pkg::FPC_OP_READ: c = {1'b1, a, 8'h00};
			fpc_pkg::FPC_OP_RESET: c = {1'b0, a, `FPC_CMD_RESET};
			fpc_pkg::FPC_OP_AUTOSEL_READ:
				if (i == 4'h2)
					c = {1'b0, `FPC_ADDR_UNLOCK1, `FPC_CMD_AUTOSEL};
				else if (i == 4'h3)
					c = {1'b1, a, 8'h00};
			fpc_pkg::FPC_OP_QUERY: c = {1'b0, `FPC_ADDR_QUERY, `FPC_CMD_QUERY};
			fpc_pkg::FPC_OP_PROGRAM:
				if (i == 4'h2)
					c = {1'b0, `FPC_ADDR_UNLOCK1, `FPC_CMD_PROGRAM};
				else if (i == 4'h3)
					c = {1'b0, a, d};
			fpc_pkg::FPC_OP_BUF_PROGRAM:
				// Single-location buffer load; count written as locations minus one
				if (i == 4'h2)
					c = {1'b0, a, `FPC_CMD_BUF_LOAD};
				else if (i == 4'h3)
					c = {1'b0, a, 8'h00};
				else if (i == 4'h4)
					c = {1'b0, a, d};
				else if (i == 4'h5)
					c = {1'b0, a, `FPC_CMD_BUF_CONFIRM};
			fpc_pkg::FPC_OP_BUF_ABORT_RESET:
				if (i == 4'h2)
					c = {1'b0, `FPC_ADDR_UNLOCK2, `FPC_CMD_RESET};
			fpc_pkg::FPC_OP_BYPASS_ENTER:
				if (i == 4'h2)
					c = {1'b0, `FPC_ADDR_UNLOCK1, `FPC_CMD_BYPASS};
			fpc_pkg::FPC_OP_BYPASS_PROGRAM:
				c = (i == 4'h0) ? {1'b0, a, `FPC_CMD_PROGRAM} : {1'b0, a, d};
			fpc_pkg::FPC_OP_BYPASS_RESET:
				c = (i == 4'h0) ? {1'b0, a, `FPC_CMD_EXIT1} : {1'b0, a, `FPC_CMD_EXIT2};
			fpc_pkg::FPC_OP_SECTOR_ERASE, fpc_pkg::FPC_OP_CHIP_ERASE:
				if (i == 4'h2)
					c = {1'b0, `FPC_ADDR_UNLOCK1, `FPC_CMD_ERASE};
				else if (i == 4'h4)
					c = {1'b0, `FPC_ADDR_UNLOCK2, `FPC_DATA_UNLOCK2};
				else if (i == 4'h5)
					c = (op == 5'(fpc_pkg::FPC_OP_SECTOR_ERASE)) ?
						{1'b0, a, `FPC_CMD_SECTOR_ERASE} :
						{1'b0, `FPC_ADDR_UNLOCK1, `FPC_CMD_CHIP_ERASE};
			fpc_pkg::FPC_OP_SUSPEND: c = {1'b0, a, `FPC_CMD_SUSPEND};
			fpc_pkg::FPC_OP_RESUME: c = {1'b0, a, `FPC_CMD_RESUME};
			fpc_pkg::FPC_OP_SET_ENTER:
				if (i == 4'h2)
					c = {1'b0, `FPC_ADDR_UNLOCK1, d};
			fpc_pkg::FPC_OP_SET_PROGRAM:
				c = (i == 4'h0) ? {1'b0, a, `FPC_CMD_PROGRAM} : {1'b0, a, d};
			fpc_pkg::FPC_OP_SET_ERASE_ALL:
				c = (i == 4'h0) ? {1'b0, a, `FPC_CMD_ERASE} :
					{1'b0, 24'h000000, `FPC_CMD_SECTOR_ERASE};
			fpc_pkg::FPC_OP_SET_READ: c = {1'b1, a, 8'h00};
			fpc_pkg::FPC_OP_SET_EXIT:
				c = (i == 4'h0) ? {1'b0, a, `FPC_CMD_EXIT1} : {1'b0, a, `FPC_CMD_EXIT2};
			fpc_pkg::FPC_OP_PW_UNLOCK:
				if (i == 4'h0)
					c = {1'b0, 24'h000000, `FPC_CMD_BUF_LOAD};
				else if (i == 4'h1)
					c = {1'b0, 24'h000000, `FPC_CMD_PW_UNLOCK2};
				else if (i == 4'(SEQ_MAX - 2))
					c = {1'b0, 24'h000000, `FPC_CMD_BUF_CONFIRM};
				else
					c = {1'b0, 24'(i - 4'h2), pw[8*(i-4'h2) +: 8]};
			default: c = {1'b1, a, 8'h00};
		endcase
		return c;
	endfunction : seq_cycle

	function automatic logic [3:0] seq_len(input logic [4:0] op);
		unique case (fpc_pkg::fpc_op_e'(op))
			fpc_pkg::FPC_OP_READ, fpc_pkg::FPC_OP_RESET, fpc_pkg::FPC_OP_QUERY,
			fpc_pkg::FPC_OP_SUSPEND, fpc_pkg::FPC_OP_RESUME, fpc_pkg::FPC_OP_SET_READ: return 4'h1;
			fpc_pkg::FPC_OP_BYPASS_PROGRAM, fpc_pkg::FPC_OP_BYPASS_RESET,
			fpc_pkg::FPC_OP_SET_PROGRAM, fpc_pkg::FPC_OP_SET_ERASE_ALL,
			fpc_pkg::FPC_OP_SET_EXIT: return 4'h2;
			fpc_pkg::FPC_OP_BUF_ABORT_RESET, fpc_pkg::FPC_OP_BYPASS_ENTER,
			fpc_pkg::FPC_OP_SET_ENTER: return 4'h3;
			fpc_pkg::FPC_OP_AUTOSEL_READ, fpc_pkg::FPC_OP_PROGRAM: return 4'h4;
			fpc_pkg::FPC_OP_SECTOR_ERASE, fpc_pkg::FPC_OP_CHIP_ERASE: return 4'h6;
			fpc_pkg::FPC_OP_BUF_PROGRAM: return 4'h6;
			fpc_pkg::FPC_OP_PW_UNLOCK: return 4'(SEQ_MAX - 1);
			default: return 4'h0;
		endcase
	endfunction : seq_len

	// Refuses orders the device would ignore or that break protocol
	function automatic logic op_illegal(input fpc_host_s s, input logic [4:0] op,
		input logic [7:0] d);
		logic bad;
		bad = 1'b0;
		unique case (fpc_pkg::fpc_op_e'(op))
			fpc_pkg::FPC_OP_QUERY: bad = s.bypass || s.in_set || s.suspended;
			fpc_pkg::FPC_OP_BYPASS_PROGRAM, fpc_pkg::FPC_OP_BYPASS_RESET: bad = !s.bypass;
			fpc_pkg::FPC_OP_SUSPEND: bad = !s.erasing;
			fpc_pkg::FPC_OP_RESUME: bad = !s.suspended;
			fpc_pkg::FPC_OP_SET_ENTER:
				bad = s.in_set || !(d == `FPC_CMD_LOCKREG || d == `FPC_CMD_PASSWORD ||
					d == `FPC_CMD_PERSIST || d == `FPC_CMD_FREEZE ||
					d == `FPC_CMD_VOLATILE);
			fpc_pkg::FPC_OP_SET_PROGRAM:
				bad = !s.in_set || (s.set_kind == `FPC_CMD_LOCKREG &&
					!d[`FPC_LOCK_PERSIST] && !d[`FPC_LOCK_PASSWORD]);
			fpc_pkg::FPC_OP_SET_ERASE_ALL, fpc_pkg::FPC_OP_SET_READ,
			fpc_pkg::FPC_OP_SET_EXIT, fpc_pkg::FPC_OP_PW_UNLOCK: bad = !s.in_set;
			fpc_pkg::FPC_OP_READ, fpc_pkg::FPC_OP_RESET, fpc_pkg::FPC_OP_AUTOSEL_READ,
			fpc_pkg::FPC_OP_PROGRAM, fpc_pkg::FPC_OP_BUF_PROGRAM,
			fpc_pkg::FPC_OP_BUF_ABORT_RESET, fpc_pkg::FPC_OP_BYPASS_ENTER,
			fpc_pkg::FPC_OP_SECTOR_ERASE, fpc_pkg::FPC_OP_CHIP_ERASE: bad = s.in_set;
			default: bad = 1'b1;
		endcase
		return bad;
	endfunction : op_illegal

	logic [32:0] cyc;

	always_comb
	begin
		nxt = cur;
		cyc = seq_cycle(cur.op, cur.step, cur.addr, cur.data, cur.pw);
		// Flash data is a pin: three stages, taken once the last two agree
		nxt.dq_s1 = i_flash_dq_in;
		nxt.dq_s2 = cur.dq_s1;
		nxt.dq_s3 = cur.dq_s2;
		if (cur.dq_s2 == cur.dq_s3) nxt.dq_ok = cur.dq_s3;
		nxt.rd_q = 32'h00000000;
		if (i_reg_rd)
		begin
			unique case (i_reg_addr)
				`FPC_REG_ADDR: nxt.rd_q = {8'h00, cur.addr};
				`FPC_REG_DATA: nxt.rd_q = {24'h000000, cur.data};
				`FPC_REG_STATUS: nxt.rd_q = {25'h0000000, cur.autosel, cur.in_set,
					cur.erasing, cur.suspended, cur.bypass, cur.refused, cur.busy};
				`FPC_REG_RDATA: nxt.rd_q = {24'h000000, cur.rdata};
				`FPC_REG_PW_LO: nxt.rd_q = cur.pw[31:0];
				`FPC_REG_PW_HI: nxt.rd_q = cur.pw[63:32];
				default: nxt.rd_q = 32'h00000000;
			endcase
		end
		if (i_reg_wr && !cur.busy)
		begin
			unique case (i_reg_addr)
				`FPC_REG_ADDR: nxt.addr = i_reg_wdata[23:0];
				`FPC_REG_DATA: nxt.data = i_reg_wdata[7:0];
				`FPC_REG_PW_LO: nxt.pw[31:0] = i_reg_wdata;
				`FPC_REG_PW_HI: nxt.pw[63:32] = i_reg_wdata;
				`FPC_REG_CMD:
				begin
					nxt.refused = op_illegal(cur, i_reg_wdata[4:0], cur.data);
					if (!nxt.refused)
					begin
						nxt.op = i_reg_wdata[4:0];
						nxt.step = 4'h0;
						nxt.nsteps = seq_len(i_reg_wdata[4:0]);
						nxt.busy = 1'b1;
						nxt.st = fpc_pkg::FPC_SETUP;
					end
				end
				default: ;
			endcase
		end
		unique case (cur.st)
			fpc_pkg::FPC_IDLE: ;
			fpc_pkg::FPC_SETUP:
			begin
				nxt.fa = cyc[31:8];
				nxt.fd = cyc[7:0];
				nxt.oe_dq = !cyc[32];
				nxt.ce_n = 1'b0;
				nxt.tmr = 5'h00;
				nxt.st = fpc_pkg::FPC_STROBE;
			end
			fpc_pkg::FPC_STROBE:
			begin
				nxt.we_n = cyc[32];
				nxt.oe_n = !cyc[32];
				nxt.st = cyc[32] ? fpc_pkg::FPC_RDWAIT : fpc_pkg::FPC_HOLD;
			end
			fpc_pkg::FPC_HOLD, fpc_pkg::FPC_RDWAIT:
			begin
				nxt.tmr = cur.tmr + 5'h01;
				if (cur.tmr == 5'((cur.st == fpc_pkg::FPC_HOLD ? TW : TR) - 1))
				begin
					if (cur.st == fpc_pkg::FPC_RDWAIT)
						nxt.rdata = cur.dq_ok;
					nxt.we_n = 1'b1;
					nxt.oe_n = 1'b1;
					nxt.ce_n = 1'b1;
					nxt.oe_dq = 1'b0;
					nxt.step = cur.step + 4'h1;
					nxt.st = (cur.step + 4'h1 == cur.nsteps) ?
						fpc_pkg::FPC_DONE : fpc_pkg::FPC_SETUP;
				end
			end
			fpc_pkg::FPC_DONE:
			begin
				nxt.busy = 1'b0;
				nxt.st = fpc_pkg::FPC_IDLE;
				unique case (fpc_pkg::fpc_op_e'(cur.op))
					fpc_pkg::FPC_OP_RESET: {nxt.autosel, nxt.erasing} = 2'b00;
					fpc_pkg::FPC_OP_AUTOSEL_READ: nxt.autosel = 1'b1;
					fpc_pkg::FPC_OP_BYPASS_ENTER: nxt.bypass = 1'b1;
					fpc_pkg::FPC_OP_BYPASS_RESET: nxt.bypass = 1'b0;
					fpc_pkg::FPC_OP_SECTOR_ERASE: nxt.erasing = 1'b1;
					fpc_pkg::FPC_OP_SUSPEND: {nxt.erasing, nxt.suspended} = 2'b01;
					fpc_pkg::FPC_OP_RESUME: {nxt.suspended, nxt.erasing} = 2'b01;
					// Set kind decides which program data is legal
					fpc_pkg::FPC_OP_SET_ENTER: {nxt.in_set, nxt.set_kind} = {1'b1, cur.data};
					fpc_pkg::FPC_OP_SET_EXIT: nxt.in_set = 1'b0;
					default: ;
				endcase
			end
		endcase
		if (i_rst)
		begin
			nxt = '0;
			{nxt.ce_n, nxt.we_n, nxt.oe_n} = 3'b111;
		end
	end

	always_ff @(posedge i_clk)
	begin
		cur <= nxt;
	end

	assign o_reg_rdata = cur.rd_q;
	assign o_flash_addr = cur.fa[ADDR_W-1:0];
	assign o_flash_dq_out = cur.fd;
	assign o_flash_dq_oe = cur.oe_dq;
	assign o_flash_ce_n = cur.ce_n;
	assign o_flash_we_n = cur.we_n;
	assign o_flash_oe_n = cur.oe_n;
endmodule : fpc_host
`default_nettype wire

/* File: fpc_host_assertions.sv */
// Checker for the flash-side bus of fpc_host and its register read port.
// Bound to fpc_host; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module fpc_host_checker #(
	parameter int ADDR_W = 24
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [31:0] o_reg_rdata,
	input wire logic [ADDR_W-1:0] o_flash_addr,
	input wire logic [7:0] o_flash_dq_out,
	input wire logic o_flash_dq_oe,
	input wire logic [7:0] i_flash_dq_in,
	input wire logic o_flash_ce_n,
	input wire logic o_flash_we_n,
	input wire logic o_flash_oe_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_unlock1;
		$fell(o_flash_we_n) && o_flash_addr[11:0] == 12'haaa && o_flash_dq_out == 8'haa;
	endsequence
	sequence s_unlock2;
		$fell(o_flash_we_n) && o_flash_addr[11:0] == 12'h555 && o_flash_dq_out == 8'h55;
	endsequence
	unlock_order_a: assert property (s_unlock1 |-> ##[6:8] s_unlock2)
		else $error("second unlock cycle missing");
	we_pulse_a: assert property ($fell(o_flash_we_n) |-> !o_flash_we_n[*5] ##1 o_flash_we_n)
		else $error("write strobe not five cycles");
	rd_pulse_a: assert property ($fell(o_flash_oe_n) |-> ##14 !o_flash_oe_n ##1 o_flash_oe_n)
		else $error("read strobe not fifteen cycles");
	ce_setup_a: assert property (($fell(o_flash_we_n) || $fell(o_flash_oe_n)) |-> !$past(o_flash_ce_n))
		else $error("no chip select setup cycle");
	strobe_excl_a: assert property (!(!o_flash_we_n && !o_flash_oe_n))
		else $error("read and write strobes together");
	write_drive_a: assert property (!o_flash_we_n |-> o_flash_dq_oe && !o_flash_ce_n)
		else $error("write without data drive");
	read_float_a: assert property (!o_flash_oe_n |-> !o_flash_dq_oe)
		else $error("data driven during read");
	write_hold_a: assert property (!o_flash_we_n && !$past(o_flash_we_n) |-> $stable(o_flash_addr) && $stable(o_flash_dq_out))
		else $error("address or data moved under write");
	rise_together_a: assert property ($rose(o_flash_we_n) |-> $rose(o_flash_ce_n) && !o_flash_dq_oe)
		else $error("strobes did not rise together");
	rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
		else $error("read data outside its cycle");
endmodule : fpc_host_checker
bind fpc_host fpc_host_checker #(.ADDR_W(ADDR_W)) chk_u (.i_clk(i_clk), .i_rst(i_rst),
	.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_flash_addr(o_flash_addr),
	.o_flash_dq_out(o_flash_dq_out), .o_flash_dq_oe(o_flash_dq_oe),
	.i_flash_dq_in(i_flash_dq_in), .o_flash_ce_n(o_flash_ce_n),
	.o_flash_we_n(o_flash_we_n), .o_flash_oe_n(o_flash_oe_n));
`default_nettype wire

/* File: fpc_flash_model.sv */
// Behavioural flash device: logs write cycles, answers reads by mode.
// Assumes registered host strobes; samples them on the host clock.
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_model (
	input wire logic i_clk,
	input wire logic [23:0] i_addr,
	input wire logic [7:0] i_dq,
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	output logic [7:0] o_dq
);
	logic [23:0] wa[1024];
	logic [7:0] wd[1024];
	int n = 0;
	int st = 0;
	// Mode: 0 array, 1 identification, 2 protection set
	logic [1:0] md = 0;
	logic [7:0] kind = 0;
	logic [7:0] lreg = 8'hff;
	logic [23:0] la = 0;
	logic [7:0] ld = 0;
	logic [7:0] prv = 0;
	logic [7:0] rv;
	logic [3:0] plock = 0;
	logic [3:0] vlock = 0;
	logic pg = 0;
	logic pwe = 1;
	logic frz = 0;
	wire [1:0] ws = la[17:16];
	wire [1:0] rs = i_addr[17:16];
	always @(posedge i_clk)
	begin
		pwe <= i_we_n;
		if (!i_we_n && !i_ce_n)
		begin
			la <= i_addr;
			ld <= i_dq;
		end
		if (i_we_n && !pwe)
		begin
			wa[n] <= la;
			wd[n] <= ld;
			n <= n + 1;
			prv <= ld;
			st <= (st == 0 && la == 24'haaa && ld == 8'haa) ? 1 :
				(st == 1 && la == 24'h555 && ld == 8'h55) ? 2 : 0;
			if (ld == 8'hf0 && md != 2) md <= 0;
			if (st == 2 && ld == 8'h90) md <= 1;
			if (st == 2 && ld inside {8'h40, 8'h60, 8'hc0, 8'h50, 8'he0})
			begin
				md <= 2;
				kind <= ld;
			end
			if (md == 2 && prv == 8'h90 && ld == 8'h00) md <= 0;
			pg <= md == 2 && ld == 8'ha0 && !pg;
			if (pg && kind == 8'h40) lreg <= lreg & ld;
			if (pg && kind == 8'hc0) plock[ws] <= 1'b1;
			if (pg && kind == 8'h50) frz <= 1'b1;
			if (pg && kind == 8'he0) vlock[ws] <= ld == 8'h00;
			if (md == 2 && kind == 8'hc0 && prv == 8'h80 && ld == 8'h30) plock <= 4'h0;
		end
	end
	always_comb
	begin
		if (md == 1)
			rv = i_addr[7:0] == 8'h06 ? {!lreg[0], 7'h00} : {7'h00, plock[rs] | vlock[rs]};
		else if (md == 2)
			rv = kind == 8'h40 ? lreg :
				{7'h00, !(kind == 8'h50 ? frz : kind == 8'he0 ? vlock[rs] : plock[rs])};
		else
			rv = i_addr[7:0] ^ 8'h5a;
	end
	// Released bus shows the inverse so a stale sample cannot match by luck
	assign o_dq = (!i_oe_n && !i_ce_n) ? rv : ~rv;
endmodule : fpc_flash_model
`default_nettype wire

/* File: test_flash_protect_command_decoder.sv */
// Self-checking bench for fpc_host against the flash device model.
// Register port driven at rising edges; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module test_flash_protect_command_decoder;
	typedef struct packed {
		logic [4:0] op;
		logic [23:0] a;
		logic [7:0] d;
		logic [3:0] nw;
		logic [7:0] ld;
		logic rf;
		logic cr;
		logic [7:0] rv;
	} fpc_row_s;
	fpc_row_s rows[37] = '{
		'{0, 24'h010020, 0, 0, 0, 0, 1, 8'h7a}, '{1, 0, 0, 1, 8'hf0, 0, 0, 0},
		'{2, 24'h010004, 0, 3, 8'h90, 0, 1, 0}, '{3, 0, 0, 1, 8'h98, 0, 0, 0},
		'{1, 0, 0, 1, 8'hf0, 0, 0, 0}, '{2, 24'h000006, 0, 3, 8'h90, 0, 1, 0},
		'{1, 0, 0, 1, 8'hf0, 0, 0, 0}, '{4, 24'h000100, 8'h3c, 4, 8'h3c, 0, 0, 0},
		'{5, 24'h000200, 8'h11, 6, 8'h29, 0, 0, 0}, '{7, 0, 0, 3, 8'h20, 0, 0, 0},
		'{8, 24'h000300, 8'h22, 2, 8'h22, 0, 0, 0}, '{9, 0, 0, 2, 0, 0, 0, 0},
		'{12, 0, 0, 0, 0, 1, 0, 0}, '{13, 0, 0, 0, 0, 1, 0, 0},
		'{10, 24'h010000, 0, 6, 8'h30, 0, 0, 0}, '{12, 0, 0, 1, 8'hb0, 0, 0, 0},
		'{13, 0, 0, 1, 8'h30, 0, 0, 0}, '{14, 0, 8'he0, 3, 8'he0, 0, 0, 0},
		'{15, 24'h010000, 0, 2, 0, 0, 0, 0}, '{17, 24'h010000, 0, 0, 0, 0, 1, 0},
		'{15, 24'h010000, 1, 2, 1, 0, 0, 0}, '{17, 24'h010000, 0, 0, 0, 0, 1, 1},
		'{18, 0, 0, 2, 0, 0, 0, 0}, '{14, 0, 8'hc0, 3, 8'hc0, 0, 0, 0},
		'{16, 0, 0, 2, 8'h30, 0, 0, 0}, '{17, 24'h010000, 0, 0, 0, 0, 1, 1},
		'{15, 24'h010000, 0, 2, 0, 0, 0, 0}, '{18, 0, 0, 2, 0, 0, 0, 0},
		'{2, 24'h010004, 0, 3, 8'h90, 0, 1, 1}, '{1, 0, 0, 1, 8'hf0, 0, 0, 0},
		'{14, 0, 8'h40, 3, 8'h40, 0, 0, 0}, '{15, 0, 8'hf9, 0, 0, 1, 0, 0},
		'{17, 0, 0, 0, 0, 0, 1, 8'hff}, '{18, 0, 0, 2, 0, 0, 0, 0},
		'{14, 0, 8'h50, 3, 8'h50, 0, 0, 0}, '{15, 0, 0, 2, 0, 0, 0, 0},
		'{17, 0, 0, 0, 0, 0, 1, 8'h00}};
	logic i_clk = 0;
	logic i_rst = 1;
	logic [3:0] ra = 0;
	logic [31:0] wdat = 0;
	logic wr = 0;
	logic rd = 0;
	logic [31:0] rdat;
	logic [23:0] fa;
	logic [7:0] fdo;
	logic [7:0] fdi;
	logic foe;
	logic fce;
	logic fwe;
	logic frd;
	logic [31:0] v;
	int n_errors = 0;
	int samples_checked = 0;
	int n0;
	always #4 i_clk = ~i_clk;
	fpc_host #(.ADDR_W(24), .BUF_PAGE_W(5)) dut_u (.i_clk(i_clk), .i_rst(i_rst),
		.i_reg_addr(ra), .i_reg_wdata(wdat), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdat), .o_flash_addr(fa), .o_flash_dq_out(fdo), .o_flash_dq_oe(foe),
		.i_flash_dq_in(fdi), .o_flash_ce_n(fce), .o_flash_we_n(fwe), .o_flash_oe_n(frd));
	fpc_flash_model fm (.i_clk(i_clk), .i_addr(fa), .i_dq(fdo), .i_ce_n(fce),
		.i_we_n(fwe), .i_oe_n(frd), .o_dq(fdi));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			n_errors++;
		end
	endtask : chk
	// One strobe cycle; read data taken in the cycle after the strobe
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		ra <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		@(posedge i_clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 v = rdat;
	endtask : bus
	task automatic op(input logic [4:0] o, input logic [23:0] a, input logic [7:0] d);
		int k;
		n0 = fm.n;
		bus(1'b1, 4'h1, 32'(a));
		bus(1'b1, 4'h2, 32'(d));
		bus(1'b1, 4'h0, 32'(o));
		for (k = 0; k < 300; k++)
		begin
			bus(1'b0, 4'h3, 32'h0);
			if (v[0] === 1'b0) break;
		end
		if (k == 300) n_errors++;
	endtask : op
	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#400000;
		n_errors++;
		report_and_stop;
	end
	initial
	begin
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		#1 chk({fce, fwe, frd, foe}, 32'he);
		bus(1'b0, 4'h3, 32'h0);
		chk(v, 32'h0);
		bus(1'b0, 4'hf, 32'h0);
		chk(v, 32'h0);
		foreach (rows[i])
		begin
			op(rows[i].op, rows[i].a, rows[i].d);
			chk(32'(v[1]), 32'(rows[i].rf));
			chk(32'(fm.n - n0), 32'(rows[i].nw));
			if (rows[i].nw != 0) chk(32'(fm.wd[fm.n - 1]), 32'(rows[i].ld));
			if (rows[i].cr)
			begin
				bus(1'b0, 4'h4, 32'h0);
				chk(32'(v[7:0]), 32'(rows[i].rv));
			end
		end
		op(5'd18, 24'h0, 8'h00);
		op(5'd14, 24'h0, 8'h12);
		chk(32'(v[1]), 32'h1);
		op(5'd14, 24'h0, 8'h60);
		chk(32'(v[1]), 32'h0);
		bus(1'b1, 4'h5, 32'h44332211);
		bus(1'b1, 4'h6, 32'h88776655);
		op(5'd19, 24'h0, 8'h00);
		chk(32'(fm.n - n0), 32'd11);
		chk({fm.wd[n0], fm.wd[n0 + 1], fm.wd[n0 + 10]}, 32'h250329);
		for (int k = 0; k < 8; k++)
			chk({fm.wa[n0 + 2 + k][7:0], fm.wd[n0 + 2 + k]}, {8'(k), 8'((k + 1) * 17)});
		op(5'd18, 24'h0, 8'h00);
		op(5'd7, 24'h0, 8'h00);
		op(5'd6, 24'h0, 8'h00);
		chk({fm.wd[n0], fm.wd[n0 + 2]}, 32'haaf0);
		op(5'd5, 24'h000234, 8'h5a);
		chk(32'(fm.wd[n0 + 3]), 32'h0);
		chk(32'(fm.wa[n0 + 4] >> 5), 32'(24'h000234 >> 5));
		// Reset in mid-cycle must drop every strobe at once
		bus(1'b1, 4'h0, 32'd4);
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b1;
		@(posedge i_clk);
		i_rst <= 1'b0;
		#1 chk({fce, fwe, frd, foe}, 32'he);
		bus(1'b0, 4'h3, 32'h0);
		chk(32'(v[0]), 32'h0);
		report_and_stop;
	end
endmodule : test_flash_protect_command_decoder
`default_nettype wire
